/* hdl/program_memory_indirect_read.sv */
`timescale 1ns/1ns
// Notes on behaviour
// - pointer high byte bit 7 set routes indirect reads to program memory
// - program memory read returns only low eight bits of the word
// - indirect writes while program memory selected are dropped
// - program memory indirect access takes exactly one extra cycle
// - select clear: pointer 0x000-0xfff is absolute data address
module program_memory_indirect_read (
    // clock and reset
    input  wire logic        CLK_SYS,
    input  wire logic        RSTN,
    // indirect pointer
    input  wire logic [7:0]  INDIRECT_POINTER_HIGH,
    input  wire logic [7:0]  INDIRECT_POINTER_LOW,
    // core access through the indirect access port
    input  wire logic        PORT_RD,
    input  wire logic        PORT_WR,
    input  wire logic [7:0]  PORT_WDATA,
    // program memory read side
    output logic [14:0]      PM_ADDR,
    output logic             PM_RD,
    input  wire logic [13:0] PM_RDATA,
    // data memory side
    output logic [11:0]      DM_ADDR,
    output logic             DM_RD,
    output logic             DM_WR,
    output logic [7:0]       DM_WDATA,
    input  wire logic [7:0]  DM_RDATA,
    // answer to the core
    output logic [7:0]       WORK_DATA,
    output logic             WORK_VALID,
    output logic             CORE_STALL
);
    logic [15:0] ptr;
    logic        pm_sel;
    logic        pm_go;
    logic        busy;
    logic        dm_go;
    logic        wr_go;
    logic [14:0] pm_addr_q;
    logic [14:0] pm_addr_d;
    logic        pm_rd_q;
    logic        pm_rd_d;
    logic [11:0] dm_addr_q;
    logic [11:0] dm_addr_d;
    logic        dm_rd_q;
    logic        dm_rd_d;
    logic        dm_wr_q;
    logic        dm_wr_d;
    logic [7:0]  dm_wdata_q;
    logic [7:0]  dm_wdata_d;
    logic [7:0]  work_q;
    logic [7:0]  work_d;
    logic        valid_q;
    logic        valid_d;
    logic        stall_q;
    logic        stall_d;
    logic        pm_wait_q;
    logic        pm_wait_d;
    logic        dm_wait_q;
    logic        dm_wait_d;

    assign ptr    = {INDIRECT_POINTER_HIGH, INDIRECT_POINTER_LOW};
    assign pm_sel = ptr[pm_read_pkg::SEL_BIT];
    // new accesses are ignored while an extended one is still running
    assign pm_go  = PORT_RD && pm_sel && !busy && !pm_wait_q;
    assign dm_go  = PORT_RD && !pm_sel && !busy && !pm_wait_q;
    // a write aimed at program memory never reaches any memory
    assign wr_go  = PORT_WR && !pm_sel && !busy && !pm_wait_q;

    stall_counter u_stall (
        .clk   (CLK_SYS),
        .rstn  (RSTN),
        .start (pm_go),
        .busy  (busy)
    );

    // program memory path: address, strobe and the extra cycle
    always_comb begin
        pm_addr_d = pm_addr_q;
        pm_rd_d   = 1'b0;
        stall_d   = 1'b0;
        pm_wait_d = 1'b0;
        if (pm_go) begin
            pm_addr_d = ptr[pm_read_pkg::PM_ADDR_W-1:0];
            pm_rd_d   = 1'b1;
            stall_d   = 1'b1;
            pm_wait_d = 1'b1;
        end
    end

    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            pm_addr_q <= 15'h0000;
            pm_rd_q   <= 1'b0;
            stall_q   <= 1'b0;
            pm_wait_q <= 1'b0;
        end else begin
            pm_addr_q <= pm_addr_d;
            pm_rd_q   <= pm_rd_d;
            stall_q   <= stall_d;
            pm_wait_q <= pm_wait_d;
        end
    end

    // data memory path: read and write share one address register
    always_comb begin
        dm_addr_d  = dm_addr_q;
        dm_rd_d    = 1'b0;
        dm_wr_d    = 1'b0;
        dm_wdata_d = dm_wdata_q;
        dm_wait_d  = 1'b0;
        if (dm_go) begin
            dm_addr_d = ptr[pm_read_pkg::DATA_ADDR_W-1:0];
            dm_rd_d   = 1'b1;
            dm_wait_d = 1'b1;
        end
        if (wr_go) begin
            dm_addr_d  = ptr[pm_read_pkg::DATA_ADDR_W-1:0];
            dm_wr_d    = 1'b1;
            dm_wdata_d = PORT_WDATA;
        end
    end

    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            dm_addr_q  <= pm_read_pkg::DADDR_RST;
            dm_rd_q    <= 1'b0;
            dm_wr_q    <= 1'b0;
            dm_wdata_q <= pm_read_pkg::BYTE_RST;
            dm_wait_q  <= 1'b0;
        end else begin
            dm_addr_q  <= dm_addr_d;
            dm_rd_q    <= dm_rd_d;
            dm_wr_q    <= dm_wr_d;
            dm_wdata_q <= dm_wdata_d;
            dm_wait_q  <= dm_wait_d;
        end
    end

    // answer to the core: memories are read combinationally one cycle late
    always_comb begin
        work_d  = work_q;
        valid_d = 1'b0;
        if (pm_wait_q) begin
            work_d  = PM_RDATA[pm_read_pkg::BYTE_W-1:0];
            valid_d = 1'b1;
        end
        if (dm_wait_q) begin
            work_d  = DM_RDATA;
            valid_d = 1'b1;
        end
    end

    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            work_q  <= pm_read_pkg::BYTE_RST;
            valid_q <= 1'b0;
        end else begin
            work_q  <= work_d;
            valid_q <= valid_d;
        end
    end

    assign PM_ADDR    = pm_addr_q;
    assign PM_RD      = pm_rd_q;
    assign DM_ADDR    = dm_addr_q;
    assign DM_RD      = dm_rd_q;
    assign DM_WR      = dm_wr_q;
    assign DM_WDATA   = dm_wdata_q;
    assign WORK_DATA  = work_q;
    assign WORK_VALID = valid_q;
    assign CORE_STALL = stall_q;
endmodule

/* hdl/pm_read_pkg.sv */
package pm_read_pkg;
    localparam int PTR_W       = 16;
    localparam int SEL_BIT     = 15;
    localparam int DATA_ADDR_W = 12;
    localparam int PM_ADDR_W   = 15;
    localparam int WORD_W      = 14;
    localparam int BYTE_W      = 8;
    localparam int EXTRA_CYC   = 1;
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [11:0] DADDR_RST = 12'h000;
endpackage

/* hdl/stall_counter.sv */
`timescale 1ns/1ns
module stall_counter (
    // clock and reset
    input  wire logic clk,
    input  wire logic rstn,
    // control
    input  wire logic start,
    output logic      busy
);
    logic [1:0] cnt_q;
    logic [1:0] cnt_d;

    always_comb begin
        cnt_d = cnt_q;
        if (start) begin
            cnt_d = 2'(pm_read_pkg::EXTRA_CYC);
        end else if (cnt_q != 2'h0) begin
            cnt_d = cnt_q - 2'h1;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt_q <= 2'h0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign busy = (cnt_q != 2'h0);
endmodule

/* test/pm_read_properties.sv */
`timescale 1ns/1ns
module pm_read_properties (
    input wire logic        CLK_SYS, RSTN, PORT_RD, PORT_WR, PM_RD,
    input wire logic        DM_RD, DM_WR, WORK_VALID, CORE_STALL,
    input wire logic [7:0]  INDIRECT_POINTER_HIGH, INDIRECT_POINTER_LOW,
    input wire logic [7:0]  DM_RDATA, WORK_DATA,
    input wire logic [11:0] DM_ADDR,
    input wire logic [13:0] PM_RDATA,
    input wire logic [14:0] PM_ADDR
);
    wire logic [15:0] p = {INDIRECT_POINTER_HIGH, INDIRECT_POINTER_LOW};
    wire logic [7:0]  lo = PM_RDATA[7:0];
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!RSTN);
    // one blocked cycle follows a taken program read
    sequence idle_rd; PORT_RD && !PM_RD; endsequence
    sequence pm_req; idle_rd ##0 p[15]; endsequence
    sequence dm_req; idle_rd ##0 !p[15]; endsequence
    chk_pm_select: assert property (pm_req |=> PM_RD && !DM_RD)
        else $error("pm route");
    chk_pm_byte: assert property (pm_req |=> ##1 WORK_DATA == $past(lo))
        else $error("pm byte");
    chk_pm_valid: assert property (pm_req |=> ##1 WORK_VALID ##1 !WORK_VALID)
        else $error("pm valid");
    chk_pm_no_write: assert property (PORT_WR && p[15] |=> !DM_WR)
        else $error("pm write");
    chk_one_stall: assert property (pm_req |=> CORE_STALL ##1 !CORE_STALL)
        else $error("stall");
    chk_stall_cause: assert property (CORE_STALL |-> PM_RD)
        else $error("stall cause");
    chk_dm_addr: assert property (dm_req |=> DM_RD && !PM_RD &&
        DM_ADDR == $past(p[11:0])) else $error("dm addr");
    chk_pm_addr: assert property (pm_req |=> PM_ADDR == $past(p[14:0]))
        else $error("pm addr");
    chk_dm_data: assert property (dm_req |=> ##1 WORK_VALID &&
        WORK_DATA == $past(DM_RDATA)) else $error("dm data");
endmodule

/* test/mem_model.sv */
`timescale 1ns/1ns
module mem_model (
    // read ports
    input  wire logic [14:0] pm_addr,
    input  wire logic [11:0] dm_addr,
    output logic      [13:0] pm_rdata,
    output logic      [7:0]  dm_rdata
);
    // read only: a leaked write shows only as a strobe
    assign pm_rdata = pm_addr[13:0] ^ 14'h2d5a;
    assign dm_rdata = dm_addr[11:4] ^ dm_addr[7:0];
endmodule

/* test/program_memory_indirect_read_bench.sv */
`timescale 1ns/1ns
module program_memory_indirect_read_bench;
    logic        clk = 0, rstn = 0, rd = 0, wr = 0, pr, dr, dw, wv, st;
    logic [7:0]  hi = 8'h00, lo = 8'h00, wd = 8'h00, dd, wk, dwd;
    logic [14:0] pa;
    logic [13:0] pd;
    logic [11:0] da;
    int          err_total = 0, num_checks = 0, cyc = 0, seed = 32'h1f2c;
    always #5 clk = ~clk;
    always @(posedge clk) if (++cyc > 1000) begin
        err_total++;
        report_and_stop();
    end
    program_memory_indirect_read i_program_memory_indirect_read (
        .CLK_SYS(clk), .RSTN(rstn), .INDIRECT_POINTER_HIGH(hi),
        .INDIRECT_POINTER_LOW(lo), .PORT_RD(rd), .PORT_WR(wr),
        .PORT_WDATA(wd), .PM_ADDR(pa), .PM_RD(pr), .PM_RDATA(pd),
        .DM_ADDR(da), .DM_RD(dr), .DM_WR(dw), .DM_WDATA(dwd),
        .DM_RDATA(dd), .WORK_DATA(wk), .WORK_VALID(wv), .CORE_STALL(st));
    mem_model i_mem_model (.pm_addr(pa), .dm_addr(da), .pm_rdata(pd),
        .dm_rdata(dd));
    task automatic cmp(input logic [14:0] got, exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic acc(input logic r, w, input logic [7:0] h, l, d);
        {rd, wr, hi, lo, wd} = {r, w, h, l, d};
        @(posedge clk) #1;
        {rd, wr} = 2'h0;
        cmp(pr, r & h[7]);
        cmp(st, r & h[7]);
        cmp(dr, r & !h[7]);
        cmp(dw, w & !h[7]);
        if (r & h[7]) cmp(pa, {h[6:0], l});
        if (r & !h[7]) cmp(da, {h[3:0], l});
        if (w & !h[7]) cmp(dwd, d);
        @(posedge clk) #1;
        cmp(st, 15'h0);
        cmp(wv, r);
        if (r) cmp(wk, h[7] ? l ^ 8'h5a : {h[3:0], l[7:4]} ^ l);
        @(posedge clk) #1;
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        logic [7:0] h, l;
        repeat (3) @(posedge clk);
        #1;
        cmp({pr, dr, dw, wv, st}, 15'h0);
        rstn = 1;
        acc(1, 0, 8'h80, 8'h00, 8'h00);
        acc(1, 1, 8'hff, 8'hff, 8'h00);
        acc(1, 1, 8'h0f, 8'hff, 8'h3c);
        acc(1, 0, 8'h7f, 8'h01, 8'h00);
        repeat (60) begin
            h = $random(seed);
            l = $random(seed);
            acc(h[0], h[1], h, l, l ^ 8'h96);
        end
        report_and_stop();
    end
endmodule
bind program_memory_indirect_read pm_read_properties i_pm_read_properties (.*);
